// ===== verilog/rsmc_pkg.sv
// Operation
// - sleep only with non-zero mode and pin request or expired idle timer
// - idle timer acts only in modes 4 and 5
// - mode 1 sleeps while pin high, wakes on low level
// - finish radio activity, pass idle, then sleep
// - ignore serial and radio activity while pin-asleep
// - clear-to-send low once awake after pin sleep
// - mode 2 like mode 1 with shorter wake time
// - mode 0 never sleeps, stays ready
// - mode 4 wakes every sleep period and polls coordinator
// - no data after poll sleeps again, data keeps awake until idle expiry
// - cyclic remote drives clear-to-send low on wake when configured
// - mode 5 also wakes on falling pin edge, then clear-to-send low
// - any unicast activity restarts the idle timer
// - once pin-woken in mode 5 ignore pin, sleep on idle expiry
// - coordinator stays awake, buffers one indirect message until polled
// - drop indirect message unpolled for 2.5 sleep periods
// - broadcast traffic does not restart the idle timer
// - pin modes poll on wake only when association flag allows
package rsmc_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_KHZ = 25000;
   localparam int unsigned HIB_WAKE_US = 10200;
   localparam int unsigned DOZE_WAKE_US = 2600;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned HIB_WAKE_CYC = HIB_WAKE_US * CLK_KHZ / 1000;
   localparam int unsigned DOZE_WAKE_CYC = DOZE_WAKE_US * CLK_KHZ / 1000;
   localparam int unsigned TICK_CYC = TICK_US * CLK_KHZ / 1000;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_IDLE_TIME = 4'h4;
   localparam logic [3:0] ADDR_SLEEP_PER = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_COORD_BIT = 3;
   localparam int CTRL_ASSOC_BIT = 4;
   localparam int CTRL_CTS_BIT = 5;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [15:0] IDLE_TIME_RST = 16'h1388;
   localparam logic [15:0] SLEEP_PER_RST = 16'h0064;
   localparam logic [18:0] DROP_MULT = 19'h00005;
   // ----------------------------------------
   // modes and states
   // ----------------------------------------
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_HIB = 3'h1;
   localparam logic [2:0] MODE_DOZE = 3'h2;
   localparam logic [2:0] MODE_CYC = 3'h4;
   localparam logic [2:0] MODE_CYC_PIN = 3'h5;
   localparam logic [2:0] MODE_COORD = 3'h6;
   typedef enum logic [2:0] {
      ST_AWAKE = 3'b000,
      ST_DRAIN = 3'b001,
      ST_SLEEP = 3'b010,
      ST_WAKE = 3'b011,
      ST_POLL = 3'b100
   } rsmc_state_t;
endpackage

// ===== verilog/rsmc_top.sv
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/10ps
module rsmc_top #(
   parameter int unsigned TICK_CYCLES = rsmc_pkg::TICK_CYC,
   parameter int unsigned HIB_WAKE_CYCLES = rsmc_pkg::HIB_WAKE_CYC,
   parameter int unsigned DOZE_WAKE_CYCLES = rsmc_pkg::DOZE_WAKE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // host pins
   input wire logic sleep_request_pin,
   output logic cts_n,
   // radio core status
   input wire logic rf_busy,
   input wire logic unicast_activity,
   input wire logic broadcast_activity,
   input wire logic poll_done,
   input wire logic poll_data,
   // radio core control
   output logic poll_req,
   output logic io_enable,
   output logic asleep,
   // indirect message buffer
   input wire logic ind_store,
   input wire logic ind_poll_hit,
   output logic ind_held,
   output logic ind_send,
   output logic ind_drop
);
   import rsmc_pkg::*;

   typedef struct packed {
      rsmc_state_t st;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
      logic waitreq;
      logic [31:0] rdata;
      logic [2:0] mode;
      logic coord_en;
      logic assoc_poll;
      logic cts_cfg;
      logic [15:0] idle_time;
      logic [15:0] sleep_per;
      logic [31:0] tick_cnt;
      logic [15:0] idle_cnt;
      logic [15:0] sleep_cnt;
      logic [31:0] wake_cnt;
      logic pin_woken;
      logic cts_n;
      logic poll_req;
      logic io_en;
      logic asleep;
      logic ind_held;
      logic [17:0] ind_age;
      logic ind_send;
      logic ind_drop;
   } rsmc_regs_t;

   rsmc_regs_t r;
   rsmc_regs_t n;
   logic tick;
   logic sleep_ok;
   logic pin_mode;
   logic timed;
   logic pin_lvl;
   logic pin_fall;
   logic idle_exp;
   logic coord;

   function automatic logic [31:0] reg_read(input rsmc_regs_t s, input logic [3:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         ADDR_CTRL: begin
            v[CTRL_MODE_LSB +: 3] = s.mode;
            v[CTRL_COORD_BIT] = s.coord_en;
            v[CTRL_ASSOC_BIT] = s.assoc_poll;
            v[CTRL_CTS_BIT] = s.cts_cfg;
         end
         ADDR_IDLE_TIME: v[15:0] = s.idle_time;
         ADDR_SLEEP_PER: v[15:0] = s.sleep_per;
         ADDR_STATUS: v[5:0] = {s.pin_woken, s.ind_held, s.asleep, s.st};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   assign coord = r.coord_en || (r.mode == MODE_COORD);
   assign sleep_ok = (r.mode != MODE_OFF) && !coord;
   assign pin_mode = sleep_ok && (r.mode == MODE_HIB || r.mode == MODE_DOZE);
   assign timed = sleep_ok && (r.mode == MODE_CYC || r.mode == MODE_CYC_PIN);
   // only the second and third stages are looked at
   assign pin_lvl = r.pin_s2;
   assign pin_fall = r.pin_s3 && !r.pin_s2;
   assign tick = (r.tick_cnt == 32'(TICK_CYCLES - 1));
   assign idle_exp = timed && (r.idle_cnt >= r.idle_time);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = r;
      n.pin_s1 = sleep_request_pin;
      n.pin_s2 = r.pin_s1;
      n.pin_s3 = r.pin_s2;
      n.poll_req = 1'b0;
      n.ind_send = 1'b0;
      n.ind_drop = 1'b0;
      n.tick_cnt = tick ? 32'h0000_0000 : r.tick_cnt + 32'h0000_0001;

      // bus: answer one cycle after the request, write lands on the accepting edge
      if (r.waitreq) begin
         if (avs_read || avs_write) begin
            n.waitreq = 1'b0;
            n.rdata = reg_read(r, avs_address);
         end
      end else begin
         n.waitreq = 1'b1;
         if (avs_write) begin
            unique case (avs_address)
               ADDR_CTRL: begin
                  n.mode = avs_writedata[CTRL_MODE_LSB +: 3];
                  n.coord_en = avs_writedata[CTRL_COORD_BIT];
                  n.assoc_poll = avs_writedata[CTRL_ASSOC_BIT];
                  n.cts_cfg = avs_writedata[CTRL_CTS_BIT];
               end
               ADDR_IDLE_TIME: n.idle_time = avs_writedata[15:0];
               ADDR_SLEEP_PER: n.sleep_per = avs_writedata[15:0];
               default: n.idle_time = r.idle_time;
            endcase
         end
      end

      // idle timer: broadcasts deliberately excluded
      if (unicast_activity || rf_busy) begin
         n.idle_cnt = 16'h0000;
      end else if (tick && r.idle_cnt != 16'hFFFF) begin
         n.idle_cnt = r.idle_cnt + 16'h0001;
      end

      unique case (r.st)
         ST_AWAKE: begin
            if ((pin_mode && pin_lvl) || idle_exp) begin
               n.st = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (!sleep_ok || (pin_mode && !pin_lvl)) begin
               n.st = ST_AWAKE;
            end else if (!rf_busy) begin
               n.st = ST_SLEEP;
               n.sleep_cnt = 16'h0000;
               n.pin_woken = 1'b0;
            end
         end
         ST_SLEEP: begin
            if (!sleep_ok) begin
               n.st = ST_AWAKE;
               n.idle_cnt = 16'h0000;
            end else if (pin_mode) begin
               if (!pin_lvl) begin
                  n.st = ST_WAKE;
                  n.wake_cnt = (r.mode == MODE_HIB) ? 32'(HIB_WAKE_CYCLES - 1) : 32'(DOZE_WAKE_CYCLES - 1);
               end
            end else if (r.mode == MODE_CYC_PIN && pin_fall) begin
               n.st = ST_WAKE;
               n.pin_woken = 1'b1;
               n.wake_cnt = 32'(DOZE_WAKE_CYCLES - 1);
            end else if (tick) begin
               if (r.sleep_cnt + 16'h0001 >= r.sleep_per) begin
                  n.st = ST_WAKE;
                  n.wake_cnt = 32'(DOZE_WAKE_CYCLES - 1);
               end else begin
                  n.sleep_cnt = r.sleep_cnt + 16'h0001;
               end
            end
         end
         ST_WAKE: begin
            if (r.wake_cnt != 32'h0000_0000) begin
               n.wake_cnt = r.wake_cnt - 32'h0000_0001;
            end else if ((timed && !r.pin_woken) || (pin_mode && r.assoc_poll)) begin
               n.st = ST_POLL;
               n.poll_req = 1'b1;
            end else begin
               n.st = ST_AWAKE;
               n.idle_cnt = 16'h0000;
            end
         end
         ST_POLL: begin
            if (poll_done) begin
               if (poll_data || pin_mode || !sleep_ok) begin
                  n.st = ST_AWAKE;
                  n.idle_cnt = 16'h0000;
               end else begin
                  n.st = ST_SLEEP;
                  n.sleep_cnt = 16'h0000;
               end
            end
         end
         default: n.st = ST_AWAKE;
      endcase

      // one-deep indirect buffer; a poll beats an expiry in the same cycle
      if (!coord) begin
         n.ind_held = 1'b0;
      end else if (r.ind_held) begin
         if (ind_poll_hit) begin
            n.ind_held = 1'b0;
            n.ind_send = 1'b1;
         end else if ({r.ind_age, 1'b0} >= 19'(r.sleep_per) * DROP_MULT) begin
            n.ind_held = 1'b0;
            n.ind_drop = 1'b1;
         end else if (tick) begin
            n.ind_age = r.ind_age + 18'h00001;
         end
      end else if (ind_store && r.sleep_per != 16'h0000) begin
         n.ind_held = 1'b1;
         n.ind_age = 18'h00000;
      end

      n.io_en = !(n.st == ST_SLEEP || n.st == ST_WAKE);
      n.asleep = (n.st == ST_SLEEP);
      n.cts_n = !((n.st == ST_AWAKE && (!(n.mode == MODE_CYC || n.mode == MODE_CYC_PIN) || n.cts_cfg || n.pin_woken))
                  || (n.st == ST_POLL && n.cts_cfg));
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{st: ST_AWAKE, waitreq: 1'b1, mode: MODE_RST, idle_time: IDLE_TIME_RST,
                sleep_per: SLEEP_PER_RST, cts_n: 1'b0, io_en: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.waitreq;
   assign cts_n = r.cts_n;
   assign poll_req = r.poll_req;
   assign io_enable = r.io_en;
   assign asleep = r.asleep;
   assign ind_held = r.ind_held;
   assign ind_send = r.ind_send;
   assign ind_drop = r.ind_drop;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_no_sleep_when_off;
      @(posedge clk) disable iff (!resetn) (!sleep_ok && r.st != ST_SLEEP) |=> r.st != ST_SLEEP;
   endproperty
   a_no_sleep_when_off: assert property (p_no_sleep_when_off) else $error("slept with sleep disabled");

   property p_drain_first;
      @(posedge clk) disable iff (!resetn)
         $rose(r.asleep) |-> ($past(r.st) == ST_DRAIN && !$past(rf_busy)) || ($past(r.st) == ST_POLL && $past(poll_done));
   endproperty
   a_drain_first: assert property (p_drain_first) else $error("sleep entered without drain");

   property p_pin_level_wake;
      @(posedge clk) disable iff (!resetn) (r.st == ST_SLEEP && pin_mode && !pin_lvl) |=> r.st == ST_WAKE;
   endproperty
   a_pin_level_wake: assert property (p_pin_level_wake) else $error("low pin level did not wake");

   property p_io_gated;
      @(posedge clk) disable iff (!resetn) (r.st == ST_SLEEP || r.st == ST_WAKE) |-> !io_enable && cts_n;
   endproperty
   a_io_gated: assert property (p_io_gated) else $error("io enabled while asleep");

   property p_cts_after_pin_wake;
      @(posedge clk) disable iff (!resetn)
         (r.st == ST_WAKE && r.wake_cnt == 32'h0000_0000 && pin_mode && !r.assoc_poll) |=> !cts_n;
   endproperty
   a_cts_after_pin_wake: assert property (p_cts_after_pin_wake) else $error("cts not low after wake");

   property p_timer_restart;
      @(posedge clk) disable iff (!resetn) unicast_activity |=> r.idle_cnt == 16'h0000;
   endproperty
   a_timer_restart: assert property (p_timer_restart) else $error("activity did not restart idle timer");

   property p_bcast_ignored;
      @(posedge clk) disable iff (!resetn)
         (broadcast_activity && !unicast_activity && !rf_busy && r.st == ST_AWAKE && r.idle_cnt != 16'h0000)
         |=> r.idle_cnt != 16'h0000;
   endproperty
   a_bcast_ignored: assert property (p_bcast_ignored) else $error("broadcast restarted idle timer");

   property p_cyclic_poll;
      @(posedge clk) disable iff (!resetn)
         (r.st == ST_WAKE && r.wake_cnt == 32'h0000_0000 && timed && !r.pin_woken) |=> poll_req ##1 !poll_req;
   endproperty
   a_cyclic_poll: assert property (p_cyclic_poll) else $error("missing poll after cyclic wake");

   property p_pin_ignored_awake;
      @(posedge clk) disable iff (!resetn) (r.st == ST_AWAKE && timed && !idle_exp) |=> r.st == ST_AWAKE;
   endproperty
   a_pin_ignored_awake: assert property (p_pin_ignored_awake) else $error("left awake without timer expiry");

   property p_drop_age;
      @(posedge clk) disable iff (!resetn)
         (coord && r.ind_held && !ind_poll_hit && {r.ind_age, 1'b0} >= 19'(r.sleep_per) * DROP_MULT)
         |=> ind_drop && !ind_held;
   endproperty
   a_drop_age: assert property (p_drop_age) else $error("stale indirect message kept");

   c_pin_cycle: cover property (@(posedge clk) disable iff (!resetn) pin_mode && r.st == ST_SLEEP ##[1:300] !cts_n);
   c_poll_nodata: cover property (@(posedge clk) disable iff (!resetn) r.st == ST_POLL && poll_done && !poll_data);
   c_pin_edge_wake: cover property (@(posedge clk) disable iff (!resetn) r.st == ST_SLEEP && timed && pin_fall);
   c_ind_send: cover property (@(posedge clk) disable iff (!resetn) ind_send);
endmodule

// ===== tb/rsmc_host_model.sv
`timescale 1ns/10ps
module rsmc_host_model #(
   parameter int BYTE_CYC = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bench wish and device pins
   input wire logic want_sleep,
   input wire logic cts_n,
   output logic sleep_request_pin
);
   logic cts_n_q;
   int hold_q;
   logic cts_fall;
   assign cts_fall = cts_n_q && !cts_n;
   // pin kept low one byte time (BYTE_CYC cycles) after ready, so serial data can land
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cts_n_q <= 1'b0;
         hold_q <= 0;
         sleep_request_pin <= 1'b0;
      end else begin
         cts_n_q <= cts_n;
         if (cts_fall) begin
            hold_q <= BYTE_CYC;
         end else if (hold_q > 0) begin
            hold_q <= hold_q - 1;
         end
         sleep_request_pin <= want_sleep && hold_q == 0 && !cts_fall;
      end
   end
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
   import rsmc_pkg::*;
   localparam int TK = 4;
   localparam int HIB = 20;
   localparam int DOZE = 8;
   logic clk, resetn, avs_read, avs_write, want_sleep, rf_busy, poll_data;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd, seed;
   logic avs_waitrequest, sleep_request_pin, cts_n, unicast_activity, broadcast_activity, poll_done;
   logic poll_req, io_enable, asleep, ind_store, ind_poll_hit, ind_held, ind_send, ind_drop;
   int n_fail, compares, n, p0, n_poll;
   rsmc_top #(.TICK_CYCLES(TK), .HIB_WAKE_CYCLES(HIB), .DOZE_WAKE_CYCLES(DOZE)) uut (
      .clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .sleep_request_pin, .cts_n, .rf_busy, .unicast_activity, .broadcast_activity,
      .poll_done, .poll_data, .poll_req, .io_enable, .asleep, .ind_store, .ind_poll_hit, .ind_held,
      .ind_send, .ind_drop);
   rsmc_host_model host (.clk, .resetn, .want_sleep, .cts_n, .sleep_request_pin);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (poll_req === 1'b1) n_poll <= n_poll + 1;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic int wake_cyc(input int m);
      return (m == 1) ? HIB : DOZE;
   endfunction
   function automatic logic sig(input int w);
      case (w)
         0: return asleep;
         1: return cts_n;
         2: return poll_req;
         default: return ind_drop;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi, input string what);
      compares++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("[ERR] %0t %s took %0d", $time, what, got);
      end
   endtask
   // holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wait_sig(input int w, input logic v, input int maxc);
      #1;
      n = 0;
      while (sig(w) !== v && n < maxc) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic hold(input logic v, input int c, input string what);
      logic bad;
      bad = 1'b0;
      repeat (c) begin
         @(posedge clk);
         #1;
         bad = bad | (asleep !== v);
      end
      chk(32'(bad), 32'h0, what);
   endtask
   task automatic pulse(input int w);
      @(posedge clk);
      case (w)
         0: unicast_activity <= 1'b1;
         1: broadcast_activity <= 1'b1;
         2: poll_done <= 1'b1;
         3: ind_store <= 1'b1;
         default: ind_poll_hit <= 1'b1;
      endcase
      @(posedge clk);
      {unicast_activity, broadcast_activity, poll_done, ind_store, ind_poll_hit} <= 5'h00;
      #1;
   endtask
   task automatic stop_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test;
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      {avs_read, avs_write, want_sleep, rf_busy, poll_data, n_fail, compares} = '0;
      {unicast_activity, broadcast_activity, poll_done, ind_store, ind_poll_hit} = 5'h00;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      seed = 32'h8EE7EFF0;
      resetn = 1'b0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk({cts_n, io_enable, asleep}, 32'h2, "reset pins");
      bus(1'b0, ADDR_IDLE_TIME, 32'h0);
      chk(rd, {16'h0000, IDLE_TIME_RST}, "idle reset");
      bus(1'b0, ADDR_SLEEP_PER, 32'h0);
      chk(rd, {16'h0000, SLEEP_PER_RST}, "period reset");
      seed = xs(seed);
      bus(1'b1, 4'h2, seed);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0, "unmapped");
      bus(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0, "status ro");
      seed = xs(seed);
      bus(1'b1, ADDR_IDLE_TIME, seed);
      bus(1'b0, ADDR_IDLE_TIME, 32'h0);
      chk(rd, {16'h0000, seed[15:0]}, "idle rw");
      $display("test regs done");
      bus(1'b1, ADDR_IDLE_TIME, 32'h2);
      bus(1'b1, ADDR_SLEEP_PER, 32'h4);
      want_sleep <= 1'b1;
      hold(1'b0, 60, "mode off");
      want_sleep <= 1'b0;
      $display("test off done");
      for (int i = 1; i < 3; i++) begin
         bus(1'b1, ADDR_CTRL, (i == 2) ? 32'h12 : 32'h1);
         hold(1'b0, 40, "pin mode idle");
         p0 = n_poll;
         rf_busy <= (i == 2);
         want_sleep <= 1'b1;
         if (i == 2) hold(1'b0, 20, "drain");
         rf_busy <= 1'b0;
         wait_sig(0, 1'b1, 12);
         chk_rng(n, (i == 1) ? 3 : 1, 8, "sleep entry");
         chk({io_enable, cts_n}, 32'h1, "asleep pins");
         pulse(0);
         hold(1'b1, 10, "ignore input");
         want_sleep <= 1'b0;
         wait_sig((i == 2) ? 2 : 1, i == 2, 60);
         chk_rng(n, wake_cyc(i), wake_cyc(i) + 8, "wake time");
         poll_data <= 1'b1;
         if (i == 2) pulse(2);
         wait_sig(1, 1'b0, 6);
         chk({cts_n, io_enable}, 32'h1, "ready");
         chk(n_poll - p0, i - 1, "pin poll");
      end
      $display("test pin done");
      bus(1'b1, ADDR_CTRL, {26'h0, 1'b1, 2'h0, MODE_CYC});
      repeat (12) pulse(0);
      chk(asleep, 1'b0, "unicast keeps awake");
      repeat (9) pulse(1);
      chk(asleep, 1'b1, "broadcast ignored");
      wait_sig(2, 1'b1, 40);
      chk(cts_n, 1'b0, "cts on wake");
      poll_data <= 1'b0;
      pulse(2);
      wait_sig(0, 1'b1, 6);
      chk_rng(n, 0, 5, "no data sleeps");
      wait_sig(2, 1'b1, 40);
      chk_rng(n, 4 * TK + DOZE - TK, 4 * TK + DOZE + 6, "period");
      poll_data <= 1'b1;
      pulse(2);
      hold(1'b0, 6, "data keeps awake");
      wait_sig(0, 1'b1, 20);
      chk_rng(n, 1, 19, "idle expiry");
      $display("test cyclic done");
      bus(1'b1, ADDR_CTRL, {29'h0, MODE_CYC_PIN});
      want_sleep <= 1'b1;
      wait_sig(0, 1'b1, 30);
      chk_rng(n, 0, 29, "pin wake sleep");
      // pin must stand high past the synchroniser before the falling edge can be seen
      repeat (3) @(posedge clk);
      p0 = n_poll;
      want_sleep <= 1'b0;
      wait_sig(1, 1'b0, 30);
      chk_rng(n, 3, DOZE + 10, "edge wake");
      want_sleep <= 1'b1;
      wait_sig(0, 1'b1, 30);
      chk_rng(n, 6, 22, "pin ignored");
      chk(n_poll - p0, 32'h0, "no poll");
      $display("test pinwake done");
      bus(1'b1, ADDR_CTRL, {29'h0, MODE_COORD});
      pulse(3);
      chk(ind_held, 1'b1, "held");
      pulse(3);
      pulse(4);
      chk(ind_send, 1'b1, "send");
      @(posedge clk);
      #1;
      chk({ind_held, ind_send}, 32'h0, "one message");
      pulse(3);
      wait_sig(3, 1'b1, 80);
      chk_rng(n, 9 * TK, 11 * TK + 2, "drop age");
      chk({asleep, ind_held}, 32'h0, "coord awake");
      $display("test coord done");
      stop_test;
   end
endmodule
